// [design/ddac_i2c_slave.sv]
`timescale 1ns/1ps
// Function
// - slave only, never drives serial clock
// - standard address 000110 plus pin bit
// - alternate address 010001 plus pin bit
// - start, then address and direction bit
// - acknowledge address match on ninth pulse
// - nine pulses per byte, msb first
// - write: address, pointer, two data bytes
// - repeated start read returns two bytes
// - bare read uses stored pointer
// - master ack repeats same two bytes
// - readback layout equals write layout
// - pointer bit per channel selects target
// - word: mode, clear, load, 12-bit code in low bits
// - clear bit low zeroes all input and output registers
// - load bit low updates selected and pending outputs
// - pointer resets zero, default readback
// - both selected loads both channels
// - multi-channel readback returns default word
// - input register loads only on completion
// - output refreshes only if input rewritten
// - top two bits select channel mode
// - reset clears registers, normal mode
// - power-down keeps output register contents
module ddac_i2c_slave import ddac_pkg::*; #(
  parameter bit ALT_VARIANT = 1'b0
) (
  // system
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  // two-wire bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // address strap
  input wire logic addr_select_pin,
  // channel output registers
  output ddac_chan_s dac_a,
  output ddac_chan_s dac_b
);

  logic [2:0] sync1;
  logic [2:0] sync2;
  logic scl_q;
  logic sda_q;
  logic [7:0] rx_byte;
  ddac_state_e state;
  ddac_state_e next_state;
  logic [3:0] cnt;
  logic ack_pend;
  logic next_ack;
  logic second;
  logic next_second;
  logic [7:0] pointer;
  logic [7:0] hi_byte;
  logic [15:0] tx_word;
  logic [15:0] in_a;
  logic [15:0] in_b;
  logic dirty_a;
  logic dirty_b;

  // link-side capture runs on the bus clock itself
  ddac_link_shift u_link (
    .scl(scl),
    .sda_in(sda_in),
    .rx_byte(rx_byte)
  );

  // pins cross into the system clock through two stages
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      sync1 <= {scl, sda_in, addr_select_pin};
      sync2 <= sync1;
      scl_q <= sync2[2];
      sda_q <= sync2[1];
    end
  end

  wire scl_s = sync2[2];
  wire sda_s = sync2[1];
  wire a0_s = sync2[0];

  // bus conditions
  wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_ev = scl_s & scl_q & ~sda_q & sda_s;
  wire rise_ev = scl_s & ~scl_q;
  wire fall_ev = ~scl_s & scl_q;
  wire bus_cond = start_ev | stop_ev;
  // rx_byte settled two system cycles before scl_s shows the edge
  wire byte_done = rise_ev & (cnt == CNT_LAST_DATA);
  wire ack_rise = rise_ev & (cnt == CNT_ACK);
  wire master_nack = rx_byte[0];

  wire [5:0] addr_hi = ALT_VARIANT ? ADDR_HI_ALT : ADDR_HI_STD;
  wire [6:0] dev_addr = {addr_hi, a0_s};
  wire addr_match = (rx_byte[7:1] == dev_addr);
  wire rd_dir = rx_byte[0];

  // pointer selection and readback word
  wire sel_a = pointer[PTR_SEL_A];
  wire sel_b = pointer[PTR_SEL_B];
  wire [1:0] sel_pair = {sel_b, sel_a};
  // multi or no channel falls back to the default word READ_DEFAULT
  wire [15:0] read_word = (sel_pair == PTR_ONLY_A) ? in_a :
                          (sel_pair == PTR_ONLY_B) ? in_b : READ_DEFAULT;

  // byte framing state
  always_comb begin
    next_state = state;
    next_ack = ack_pend;
    next_second = second;
    if (start_ev) begin
      next_state = ST_ADDR;
      next_ack = 1'b0;
    end else if (stop_ev) begin
      next_state = ST_IDLE;
      next_ack = 1'b0;
    end else if (byte_done) begin
      case (state)
        ST_ADDR: begin
          if (addr_match) begin
            next_ack = 1'b1;
            next_second = 1'b0;
            next_state = rd_dir ? ST_TX : ST_PTR;
          end else begin
            next_ack = 1'b0;
            next_state = ST_IDLE;
          end
        end
        ST_PTR: begin
          next_ack = 1'b1;
          next_second = 1'b0;
          next_state = ST_DATA;
        end
        ST_DATA: begin
          next_ack = 1'b1;
          next_second = ~second;
        end
        ST_TX: begin
          next_ack = 1'b0;
        end
        ST_IDLE: begin
          next_ack = 1'b0;
        end
        default: begin
          next_ack = 1'b0;
          next_state = ST_IDLE;
        end
      endcase
    end else if (ack_rise) begin
      next_ack = 1'b0;
      if (state == ST_TX && !ack_pend) begin
        if (master_nack) begin
          next_state = ST_IDLE;
        end else begin
          next_second = ~second;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      ack_pend <= 1'b0;
      second <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      ack_pend <= next_ack;
      second <= next_second;
    end
  end

  // pulse counter within a byte
  wire [3:0] next_cnt = start_ev ? CNT_RESET :
                        !rise_ev ? cnt :
                        (cnt == CNT_ACK) ? CNT_RESET : cnt + 4'h1;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt <= CNT_RESET;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end

  // sda is only moved on a falling clock, except its release at a start or stop while the clock is high
  wire [7:0] tx_byte = second ? tx_word[7:0] : tx_word[15:8];
  wire tx_bit = tx_byte[~cnt[2:0]];
  wire drive_low = (cnt == CNT_ACK) ? ack_pend : (state == ST_TX) & ~tx_bit;
  wire next_oe_n = bus_cond ? 1'b1 : fall_ev ? ~drive_low : sda_oe_n;

  // open drain: the data output is always low, only the enable moves
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else if (ce) begin
      sda_oe_n <= next_oe_n;
      sda_out <= 1'b0;
    end
  end

  // pointer, first data byte and latched read word
  wire ptr_load = byte_done & (state == ST_PTR);
  wire hi_load = byte_done & (state == ST_DATA) & ~second;
  wire tx_load = byte_done & (state == ST_ADDR) & addr_match & rd_dir;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pointer <= PTR_RESET;
      hi_byte <= 8'h00;
      tx_word <= READ_DEFAULT;
    end else if (ce) begin
      if (ptr_load) pointer <= rx_byte;
      if (hi_load) hi_byte <= rx_byte;
      // held across repeated pairs so the master sees the same two bytes
      if (tx_load) tx_word <= read_word;
    end
  end

  // write completion: second data byte received
  wire commit = byte_done & (state == ST_DATA) & second;
  wire [15:0] new_word = {hi_byte, rx_byte};
  wire [CODE_W-1:0] new_code = new_word[CODE_W-1:0];
  wire clr_req = ~new_word[W_CLR];
  wire load_req = ~new_word[W_LOAD_OUTPUTS_N];

  wire [15:0] next_in_a = clr_req ? WORD_RESET : sel_a ? new_word : in_a;
  wire [15:0] next_in_b = clr_req ? WORD_RESET : sel_b ? new_word : in_b;
  wire load_a = ~clr_req & load_req & (dirty_a | sel_a);
  wire load_b = ~clr_req & load_req & (dirty_b | sel_b);
  wire next_dirty_a = ~clr_req & ~load_req & (dirty_a | sel_a);
  wire next_dirty_b = ~clr_req & ~load_req & (dirty_b | sel_b);
  // mode travels with the code; power-down never clears the code
  wire ddac_chan_s word_a = '{mode: next_in_a[W_MODE_HI:W_MODE_LO],
                              code: next_in_a[CODE_W-1:0]};
  wire ddac_chan_s word_b = '{mode: next_in_b[W_MODE_HI:W_MODE_LO],
                              code: next_in_b[CODE_W-1:0]};
  wire ddac_chan_s next_dac_a = clr_req ? CHAN_RESET : load_a ? word_a : dac_a;
  wire ddac_chan_s next_dac_b = clr_req ? CHAN_RESET : load_b ? word_b : dac_b;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      in_a <= WORD_RESET;
      in_b <= WORD_RESET;
      dirty_a <= 1'b0;
      dirty_b <= 1'b0;
    end else if (ce && commit) begin
      in_a <= next_in_a;
      in_b <= next_in_b;
      dirty_a <= next_dirty_a;
      dirty_b <= next_dirty_b;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dac_a <= CHAN_RESET;
      dac_b <= CHAN_RESET;
    end else if (ce && commit) begin
      dac_a <= next_dac_a;
      dac_b <= next_dac_b;
    end
  end

  // checks
  a_ack_on_match: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && byte_done && state == ST_ADDR && addr_match) |=> ack_pend)
    else $error("matched address not acknowledged");

  a_mismatch_quiet: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && byte_done && state == ST_ADDR && !addr_match) |=> (state == ST_IDLE && !ack_pend))
    else $error("mismatched address not ignored");

  a_sda_low_phase: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (sda_oe_n != $past(sda_oe_n)) |-> (!scl_q || $past(bus_cond)))
    else $error("sda moved while clock high");

  a_clear_all: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && commit && clr_req) |=> (in_a == WORD_RESET && in_b == WORD_RESET &&
                                   dac_a == CHAN_RESET && dac_b == CHAN_RESET))
    else $error("clear did not zero registers");

  a_load_updates: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && commit && !clr_req && load_req && sel_a) |=> (dac_a.code == $past(new_code)))
    else $error("load did not update output register");

  a_hold_latched: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && commit && !clr_req && !load_req) |=> ($stable(dac_a) && $stable(dac_b)))
    else $error("output register moved without load");

  a_both_channels: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && commit && !clr_req && sel_a && sel_b) |=> (in_a == in_b))
    else $error("dual write differs between channels");

  a_no_partial: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !commit |=> ($stable(in_a) && $stable(in_b)))
    else $error("input register changed mid transfer");

  a_clean_hold: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && commit && !clr_req && load_req && !sel_b && !dirty_b) |=> $stable(dac_b))
    else $error("unwritten channel refreshed");

  a_default_read: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && tx_load && sel_pair != PTR_ONLY_A && sel_pair != PTR_ONLY_B)
      |=> (tx_word == READ_DEFAULT))
    else $error("default readback word wrong");

  a_repeat_pair: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && ack_rise && state == ST_TX && !ack_pend && !master_nack && !bus_cond)
      |=> (state == ST_TX && $stable(tx_word) && second != $past(second)))
    else $error("read did not continue with same word");

  a_release_on_cond: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && bus_cond) |=> sda_oe_n)
    else $error("sda not released at start or stop");

  a_nack_ends_read: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && ack_rise && state == ST_TX && !ack_pend && master_nack && !bus_cond)
      |=> (state == ST_IDLE))
    else $error("master nack did not end transmit");

  a_mode_loads: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (ce && commit && !clr_req && load_req && sel_b)
      |=> (dac_b.mode == $past(new_word[W_MODE_HI:W_MODE_LO])))
    else $error("channel mode not taken with load");

endmodule

// [design/ddac_link_shift.sv]
`timescale 1ns/1ps
module ddac_link_shift import ddac_pkg::*; (
  // link clock and data
  input wire logic scl,
  input wire logic sda_in,
  // last eight bits seen on rising serial clock
  output logic [7:0] rx_byte
);

  // data only, no reset: the system side reads it only about two system cycles after it settled
  always_ff @(posedge scl) begin
    rx_byte <= {rx_byte[6:0], sda_in};
  end

endmodule

// [design/ddac_pkg.sv]
package ddac_pkg;

  // slave address, upper six bits per variant
  localparam logic [5:0] ADDR_HI_STD = 6'h06;
  localparam logic [5:0] ADDR_HI_ALT = 6'h11;

  // pointer byte fields
  localparam int PTR_SEL_A = 0;
  localparam int PTR_SEL_B = 1;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [1:0] PTR_ONLY_A = 2'h1;
  localparam logic [1:0] PTR_ONLY_B = 2'h2;

  // data word fields
  localparam int W_MODE_HI = 15;
  localparam int W_MODE_LO = 14;
  localparam int W_CLR = 13;
  localparam int W_LOAD_OUTPUTS_N = 12;
  localparam int CODE_W = 12;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] READ_DEFAULT = 16'h2000;

  // byte framing: bits 0..7 data, slot 8 acknowledge
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_RESET = 4'h0;

  // channel modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PD_1K = 2'h1;
  localparam logic [1:0] MODE_PD_100K = 2'h2;
  localparam logic [1:0] MODE_PD_HIZ = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_PTR = 5'h04,
    ST_DATA = 5'h08,
    ST_TX = 5'h10
  } ddac_state_e;

  typedef struct packed {
    logic [1:0] mode;
    logic [CODE_W-1:0] code;
  } ddac_chan_s;

  localparam ddac_chan_s CHAN_RESET = '{mode: MODE_NORMAL, code: 12'h000};

endpackage

// [verification/ddac_i2c_master.sv]
`timescale 1ns/1ps
module ddac_i2c_master #(
  parameter int HALF_NS = 300
) (
  // bus wires
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // idle bus: both lines released high, clock stands still
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // also serves as repeated start from a low clock
  task automatic start();
    sda_m = 1'b1;
    #(HALF_NS) scl = 1'b1;
    #(HALF_NS) sda_m = 1'b0;
    #(HALF_NS) scl = 1'b0;
  endtask

  task automatic stop();
    #(HALF_NS/4) sda_m = 1'b0;
    #(HALF_NS) scl = 1'b1;
    #(HALF_NS) sda_m = 1'b1;
    #(HALF_NS);
  endtask

  // data moves only while clock low, a quarter phase after the fall
  task automatic bit_io(input logic b, output logic r);
    #(HALF_NS/4) sda_m = b;
    #(HALF_NS) scl = 1'b1;
    #(HALF_NS) r = sda;
    scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask

  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(ack, r);
  endtask
endmodule

// [verification/dual_dac_i2c_slave_interface_bench.sv]
`timescale 1ns/1ps
module dual_dac_i2c_slave_interface_bench import ddac_pkg::*;;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic addr_select_pin = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_out;
  logic sda_oe_n;
  ddac_chan_s dac_a;
  ddac_chan_s dac_b;
  int n_fail = 0;
  int check_count = 0;
  // pull-up: released wire reads high
  wire logic sda = sda_m & (sda_oe_n | sda_out);

  always #20 sys_clk = ~sys_clk;

  ddac_i2c_slave ddac_i2c_slave_i (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .addr_select_pin(addr_select_pin), .dac_a(dac_a), .dac_b(dac_b));

  ddac_i2c_master ddac_i2c_master_i (.scl(scl), .sda_m(sda_m), .sda(sda));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [15:0] w);
    logic a0, a1, a2, a3;
    ddac_i2c_master_i.start();
    ddac_i2c_master_i.put_byte({ADDR_HI_STD, addr_select_pin, 1'b0}, a0);
    ddac_i2c_master_i.put_byte(ptr, a1);
    ddac_i2c_master_i.put_byte(w[15:8], a2);
    ddac_i2c_master_i.put_byte(w[7:0], a3);
    ddac_i2c_master_i.stop();
    check({12'h000, a0, a1, a2, a3}, 16'h0000);
  endtask

  // two words read back to back; the second follows a master acknowledge
  task automatic rd(input logic [7:0] ptr, input bit set_ptr, input logic [15:0] exp);
    logic a0 = 1'b0;
    logic a1 = 1'b0;
    logic a2;
    logic [15:0] w1, w2;
    ddac_i2c_master_i.start();
    if (set_ptr) begin
      ddac_i2c_master_i.put_byte({ADDR_HI_STD, addr_select_pin, 1'b0}, a0);
      ddac_i2c_master_i.put_byte(ptr, a1);
      ddac_i2c_master_i.start();
    end
    ddac_i2c_master_i.put_byte({ADDR_HI_STD, addr_select_pin, 1'b1}, a2);
    ddac_i2c_master_i.get_byte(1'b0, w1[15:8]);
    ddac_i2c_master_i.get_byte(1'b0, w1[7:0]);
    ddac_i2c_master_i.get_byte(1'b0, w2[15:8]);
    ddac_i2c_master_i.get_byte(1'b1, w2[7:0]);
    ddac_i2c_master_i.stop();
    check({13'h0000, a0, a1, a2}, 16'h0000);
    check(w1, exp);
    check(w2, exp);
  endtask

  task automatic dacs(input logic [15:0] ea, input logic [15:0] eb);
    check({2'b00, dac_a}, ea);
    check({2'b00, dac_b}, eb);
  endtask

  task automatic test_reset();
    dacs(16'h0000, 16'h0000);
    check({15'h0000, sda_oe_n}, 16'h0001);
    check({15'h0000, sda_out}, 16'h0000);
    rd(8'h00, 1'b0, READ_DEFAULT);
    $display("test_reset done");
  endtask

  task automatic test_hold();
    wr(8'h01, 16'h3ABC);
    dacs(16'h0000, 16'h0000);
    rd(8'h01, 1'b1, 16'h3ABC);
    $display("test_hold done");
  endtask

  // channel a pending from test_hold; then nothing pending on a
  task automatic test_load();
    wr(8'h02, 16'h6123);
    dacs(16'h0ABC, 16'h1123);
    wr(8'h02, 16'h2456);
    dacs(16'h0ABC, 16'h0456);
    wr(8'h01, 16'h2DEF);
    dacs(16'h0DEF, 16'h0456);
    $display("test_load done");
  endtask

  task automatic test_both();
    wr(8'h03, 16'hE7FF);
    dacs(16'h37FF, 16'h37FF);
    rd(8'h03, 1'b1, READ_DEFAULT);
    rd(8'h00, 1'b0, READ_DEFAULT);
    $display("test_both done");
  endtask

  task automatic test_clear();
    wr(8'h01, 16'h0000);
    dacs(16'h0000, 16'h0000);
    rd(8'h02, 1'b1, 16'h0000);
    $display("test_clear done");
  endtask

  // frozen block must ignore a whole transfer
  task automatic test_freeze();
    logic a;
    @(negedge sys_clk) ce = 1'b0;
    ddac_i2c_master_i.start();
    ddac_i2c_master_i.put_byte({ADDR_HI_STD, addr_select_pin, 1'b0}, a);
    ddac_i2c_master_i.stop();
    @(negedge sys_clk) ce = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({15'h0000, a}, 16'h0001);
    dacs(16'h0000, 16'h0000);
    $display("test_freeze done");
  endtask

  task automatic test_addr();
    logic a, b;
    ddac_i2c_master_i.start();
    ddac_i2c_master_i.put_byte({ADDR_HI_ALT, 1'b0, 1'b0}, a);
    ddac_i2c_master_i.put_byte({ADDR_HI_STD, 1'b0, 1'b0}, b);
    ddac_i2c_master_i.stop();
    check({14'h0000, a, b}, 16'h0003);
    @(negedge sys_clk) addr_select_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    ddac_i2c_master_i.start();
    ddac_i2c_master_i.put_byte({ADDR_HI_STD, 1'b0, 1'b0}, a);
    ddac_i2c_master_i.stop();
    check({15'h0000, a}, 16'h0001);
    wr(8'h01, 16'h3555);
    rd(8'h01, 1'b1, 16'h3555);
    $display("test_addr done");
  endtask

  task automatic give_verdict();
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    test_reset();
    test_hold();
    test_load();
    test_both();
    test_clear();
    test_freeze();
    test_addr();
    give_verdict();
  end

  // whole run needs under 1 ms of bus time; double it for margin
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
endmodule
